// File: core/rtcac_top.sv
`timescale 1ns/1ps
`default_nettype none
module rtcac_top
   import rtcac_pkg::*;
(
   input  wire logic                       clk,                  // core clock, 250 MHz
   input  wire logic                       rst_b,                // async reset, low
   input  wire logic                       ce,                   // clock enable
   input  wire logic [7:0]                 reg_addr,             // register offset
   input  wire logic [7:0]                 reg_wdata,            // write data
   input  wire logic                       reg_wr,               // write strobe
   output logic      [7:0]                 reg_rdata,            // read data, one cycle late
   input  wire logic [7:0]                 cur_sec,              // calendar seconds, BCD
   input  wire logic [7:0]                 cur_min,              // calendar minutes, BCD
   input  wire logic [7:0]                 cur_hour,             // calendar hours, BCD
   input  wire logic [7:0]                 cur_day,              // calendar day, BCD
   input  wire logic [7:0]                 cur_wday,             // calendar weekday
   input  wire logic                       cal_update,           // calendar just advanced
   input  wire logic [RTCAC_NUM_TICKS-1:0] src_tick,             // countdown source strobes
   input  wire logic                       alarm_irq_enable,     // alarm drives interrupt
   input  wire logic                       alarm_flag_clear,     // clear alarm flag
   input  wire logic                       countdown_flag_clear, // clear countdown flag
   output logic                            alarm_flag,           // sticky alarm flag
   output logic                            countdown_flag,       // sticky countdown flag
   output logic                            int_o,                // interrupt pin drive level
   output logic                            int_oe                // interrupt pin pulls low
);
   rtcac_tmr_if tif ();

   logic [RTCAC_NUM_FIELDS-1:0][7:0] match_q;      // second..weekday match registers
   logic [RTCAC_NUM_FIELDS-1:0][7:0] next_match;   // next match registers
   logic [RTCAC_NUM_FIELDS-1:0][7:0] cur_field;    // calendar fields in same order
   logic [RTCAC_NUM_FIELDS-1:0]      field_hit;    // field matches or is ignored
   logic [RTCAC_NUM_FIELDS-1:0]      field_dis;    // field disable bits
   logic [7:0]                       cd_value;     // countdown reload value
   logic [7:0]                       next_cd_value; // next reload value
   logic [7:0]                       cd_ctrl;      // countdown control
   logic [7:0]                       next_cd_ctrl; // next control
   logic                             value_wr;     // reload value write seen
   logic                             next_value_wr; // next write marker
   logic [7:0]                       next_rdata;   // next read data
   logic                             all_hit;      // every enabled field matches
   logic                             match_prev;   // match state at previous update
   logic                             next_match_prev; // next match state
   logic                             next_alarm_flag; // next alarm flag
   logic                             irq_req;      // interrupt wanted
   logic                             next_int_oe;  // next pin enable
   logic                             cd_irq;       // countdown interrupt term

   // packed so index i lines up with match register i
   assign cur_field = {cur_wday, cur_day, cur_hour, cur_min, cur_sec};

   // per-field compare; hour is compared on the stored bits in either hour mode
   generate
      for (genvar i = 0; i < RTCAC_NUM_FIELDS; i++) begin : g_field
         assign field_dis[i] = match_q[i][RTCAC_MATCH_DIS_BIT];
         assign field_hit[i] = field_dis[i] ||
            ((match_q[i] & RTCAC_MATCH_WMASK[i] & ~RTCAC_MATCH_RST) ==
             (cur_field[i] & RTCAC_MATCH_WMASK[i] & ~RTCAC_MATCH_RST));
      end
   endgenerate

   // ignored fields count as hits so they never hold back the rest
   // with every field disabled there is no alarm at all
   assign all_hit = (&field_hit) && !(&field_dis);

   // register writes; reserved bits are masked so they read zero
   always_comb begin
      next_match    = match_q;
      next_cd_value = cd_value;
      next_cd_ctrl  = cd_ctrl;
      next_value_wr = 1'b0;
      // unmapped offsets fall through and change nothing
      if (reg_wr) begin
         if (reg_addr == RTCAC_SEC_MATCH_ADDR) begin
            next_match[0] = reg_wdata & RTCAC_MATCH_WMASK[0];
         end else if (reg_addr == RTCAC_MIN_MATCH_ADDR) begin
            next_match[1] = reg_wdata & RTCAC_MATCH_WMASK[1];
         end else if (reg_addr == RTCAC_HOUR_MATCH_ADDR) begin
            next_match[2] = reg_wdata & RTCAC_MATCH_WMASK[2];
         end else if (reg_addr == RTCAC_DAY_MATCH_ADDR) begin
            next_match[3] = reg_wdata & RTCAC_MATCH_WMASK[3];
         end else if (reg_addr == RTCAC_WDAY_MATCH_ADDR) begin
            next_match[4] = reg_wdata & RTCAC_MATCH_WMASK[4];
         end else if (reg_addr == RTCAC_CD_VALUE_ADDR) begin
            next_cd_value = reg_wdata;
            next_value_wr = 1'b1;
         end else if (reg_addr == RTCAC_CD_CTRL_ADDR) begin
            next_cd_ctrl = reg_wdata & RTCAC_CD_CTRL_WMASK;
         end
      end
   end

   // register storage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         match_q  <= {RTCAC_NUM_FIELDS{RTCAC_MATCH_RST}};
         cd_value <= RTCAC_CD_VALUE_RST;
         cd_ctrl  <= RTCAC_CD_CTRL_RST;
         value_wr <= 1'b0;
      end else if (ce) begin
         match_q  <= next_match;
         cd_value <= next_cd_value;
         cd_ctrl  <= next_cd_ctrl;
         value_wr <= next_value_wr;
      end
   end

   // read mux; the value register returns the live count, not the reload
   always_comb begin
      next_rdata = 8'h00;
      if (reg_addr == RTCAC_SEC_MATCH_ADDR) begin
         next_rdata = match_q[0];
      end else if (reg_addr == RTCAC_MIN_MATCH_ADDR) begin
         next_rdata = match_q[1];
      end else if (reg_addr == RTCAC_HOUR_MATCH_ADDR) begin
         next_rdata = match_q[2];
      end else if (reg_addr == RTCAC_DAY_MATCH_ADDR) begin
         next_rdata = match_q[3];
      end else if (reg_addr == RTCAC_WDAY_MATCH_ADDR) begin
         next_rdata = match_q[4];
      end else if (reg_addr == RTCAC_CD_VALUE_ADDR) begin
         next_rdata = tif.count;
      end else if (reg_addr == RTCAC_CD_CTRL_ADDR) begin
         next_rdata = cd_ctrl;
      end
   end

   // read data register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (ce) begin
         reg_rdata <= next_rdata;
      end
   end

   // alarm flag: set on a rising match sampled at each calendar update
   always_comb begin
      next_match_prev = match_prev;
      next_alarm_flag = alarm_flag;
      // clear first so that a set in the same cycle wins
      if (alarm_flag_clear) begin
         next_alarm_flag = 1'b0;
      end
      if (cal_update) begin
         next_match_prev = all_hit;
         // a match that only persists does not set it again
         if (all_hit && !match_prev) begin
            next_alarm_flag = 1'b1;
         end
      end
   end

   // alarm state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         match_prev <= 1'b0;
         alarm_flag <= 1'b0;
      end else if (ce) begin
         match_prev <= next_match_prev;
         alarm_flag <= next_alarm_flag;
      end
   end

   // countdown control into the timer
   assign tif.reload    = cd_value;
   assign tif.src_sel   = rtcac_src_e'(cd_ctrl[RTCAC_SRC_HI:RTCAC_SRC_LO]);
   assign tif.run       = cd_ctrl[RTCAC_RUN_BIT];
   // a written value restarts the count on the next edge
   assign tif.reload_wr = value_wr;
   assign tif.flag_clr  = countdown_flag_clear;

   rtcac_countdown u_countdown (
      .clk      (clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .src_tick (src_tick),
      .tif      (tif)
   );

   assign countdown_flag = tif.flag;

   // countdown term: level follows the flag, pulse style uses the expiry pulse
   assign cd_irq  = cd_ctrl[RTCAC_IE_BIT] &&
                    (cd_ctrl[RTCAC_STYLE_BIT] ? tif.pulse : tif.flag);
   assign irq_req = (alarm_irq_enable && alarm_flag) || cd_irq;

   // open-drain pin: registered so the enable is glitch free
   always_comb begin
      next_int_oe = irq_req;
   end

   // pin enable register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         int_oe <= 1'b0;
      end else if (ce) begin
         int_oe <= next_int_oe;
      end
   end

   // the pin is only ever pulled low
   // limitation: no push-pull option, the pin needs its pull-up
   assign int_o = 1'b0;

   // disable bit set ignores the field entirely
   AST_FIELD_DIS: assert property (@(posedge clk) disable iff (!rst_b)
      match_q[0][RTCAC_MATCH_DIS_BIT] |-> field_hit[0])
      else $error("disabled second field still gates the alarm");
   // reserved bit 6 of hour and day reads back zero
   AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
      ce && (reg_addr == RTCAC_HOUR_MATCH_ADDR || reg_addr == RTCAC_DAY_MATCH_ADDR) |=> reg_rdata[6] == 1'b0)
      else $error("reserved bit 6 reads nonzero");
   // weekday upper bits read zero
   AST_WDAY_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
      ce && reg_addr == RTCAC_WDAY_MATCH_ADDR |=> reg_rdata[6:3] == 4'h0)
      else $error("weekday unused bits read nonzero");
   // a fresh full match at an update sets the flag next cycle
   AST_ALM_SET: assert property (@(posedge clk) disable iff (!rst_b)
      ce && cal_update && all_hit && !match_prev |=> alarm_flag)
      else $error("alarm flag not set on first match");
   // flag rises only from an update
   AST_ALM_CAUSE: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(alarm_flag) |-> $past(ce) && $past(cal_update) && $past(all_hit) && !$past(match_prev))
      else $error("alarm flag rose without a new match");
   // flag stays until cleared
   AST_ALM_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      alarm_flag && !alarm_flag_clear |=> alarm_flag)
      else $error("alarm flag dropped without a clear");
   // enabled alarm flag pulls the pin within one cycle
   AST_INT_ALARM: assert property (@(posedge clk) disable iff (!rst_b)
      ce && alarm_irq_enable && alarm_flag |=> int_oe)
      else $error("alarm did not drive interrupt");
   // countdown interrupt disabled and no alarm leaves the pin free
   AST_INT_CD_OFF: assert property (@(posedge clk) disable iff (!rst_b)
      ce && !cd_ctrl[RTCAC_IE_BIT] && !(alarm_irq_enable && alarm_flag) |=> !int_oe)
      else $error("interrupt driven while sources disabled");
   // level style follows the countdown flag
   AST_INT_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
      ce && cd_ctrl[RTCAC_IE_BIT] && !cd_ctrl[RTCAC_STYLE_BIT] && tif.flag |=> int_oe)
      else $error("level style did not follow countdown flag");
   // the checks below treat a low clock enable as a held state
   // a minute write lands whole
   AST_WR_MIN: assert property (@(posedge clk) disable iff (!rst_b)
      ce && reg_wr && reg_addr == RTCAC_MIN_MATCH_ADDR |=> match_q[1] == $past(reg_wdata))
      else $error("minute match write lost");
   // an hour write keeps bit 6 clear in either hour mode
   AST_WR_HOUR: assert property (@(posedge clk) disable iff (!rst_b)
      ce && reg_wr && reg_addr == RTCAC_HOUR_MATCH_ADDR
      |=> match_q[2] == ($past(reg_wdata) & RTCAC_MATCH_WMASK[2]))
      else $error("hour match write wrong");
   // the reload value is stored as written
   AST_WR_VALUE: assert property (@(posedge clk) disable iff (!rst_b)
      ce && reg_wr && reg_addr == RTCAC_CD_VALUE_ADDR |=> cd_value == $past(reg_wdata))
      else $error("reload value write lost");
   // unused control bits read zero
   AST_CTRL_RSVD: assert property (@(posedge clk) disable iff (!rst_b)
      ce && reg_addr == RTCAC_CD_CTRL_ADDR |=> reg_rdata[7:5] == 3'h0)
      else $error("unused control bits read nonzero");
   // each update records the compare result
   AST_MATCH_PREV: assert property (@(posedge clk) disable iff (!rst_b)
      ce && cal_update |=> match_prev == $past(all_hit))
      else $error("match state not recorded at update");
   // a match that only persists never sets a cleared flag
   AST_ALM_PERSIST: assert property (@(posedge clk) disable iff (!rst_b)
      ce && cal_update && match_prev && !alarm_flag |=> !alarm_flag)
      else $error("alarm flag set by a persisting match");
   // with every field disabled the flag cannot rise
   AST_ALM_NONE: assert property (@(posedge clk) disable iff (!rst_b)
      ce && cal_update && (&field_dis) && !alarm_flag |=> !alarm_flag)
      else $error("alarm flag set with all fields disabled");
   // pulse style: the countdown flag alone does not hold the pin
   AST_INT_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
      ce && cd_ctrl[RTCAC_STYLE_BIT] && !tif.pulse && !(alarm_irq_enable && alarm_flag) |=> !int_oe)
      else $error("pulse style held the pin");
   // an enabled second field with differing value blocks the match
   AST_SEC_HIT: assert property (@(posedge clk) disable iff (!rst_b)
      !field_dis[0] && match_q[0][RTCAC_MATCH_DIS_BIT-1:0] != cur_sec[RTCAC_MATCH_DIS_BIT-1:0] |-> !field_hit[0])
      else $error("second field matched a different value");
endmodule // rtcac_top
`default_nettype wire

// File: core/rtcac_pkg.sv
package rtcac_pkg;
   // register offsets on the register port
   localparam logic [7:0] RTCAC_SEC_MATCH_ADDR  = 8'h0b;
   localparam logic [7:0] RTCAC_MIN_MATCH_ADDR  = 8'h0c;
   localparam logic [7:0] RTCAC_HOUR_MATCH_ADDR = 8'h0d;
   localparam logic [7:0] RTCAC_DAY_MATCH_ADDR  = 8'h0e;
   localparam logic [7:0] RTCAC_WDAY_MATCH_ADDR = 8'h0f;
   localparam logic [7:0] RTCAC_CD_VALUE_ADDR   = 8'h10;
   localparam logic [7:0] RTCAC_CD_CTRL_ADDR    = 8'h11;
   // alarm fields, second through weekday
   localparam int         RTCAC_NUM_FIELDS      = 5;
   localparam int         RTCAC_MATCH_DIS_BIT   = 7;
   localparam logic [7:0] RTCAC_MATCH_RST       = 8'h80;
   // writable bits per field, listed weekday, day, hour, min, sec
   localparam logic [RTCAC_NUM_FIELDS-1:0][7:0] RTCAC_MATCH_WMASK = {8'h87, 8'hbf, 8'hbf, 8'hff, 8'hff};
   // countdown registers
   localparam logic [7:0] RTCAC_CD_VALUE_RST    = 8'h00;
   localparam logic [7:0] RTCAC_CD_CTRL_RST     = 8'h18;
   localparam logic [7:0] RTCAC_CD_CTRL_WMASK   = 8'h1f;
   localparam int         RTCAC_SRC_LO          = 3;
   localparam int         RTCAC_SRC_HI          = 4;
   localparam int         RTCAC_RUN_BIT         = 2;
   localparam int         RTCAC_IE_BIT          = 1;
   localparam int         RTCAC_STYLE_BIT       = 0;
   localparam logic [7:0] RTCAC_CD_ONE          = 8'h01;
   localparam logic [7:0] RTCAC_CD_ZERO         = 8'h00;
   // timebase strobe lanes, same order as the source codes
   localparam int         RTCAC_NUM_TICKS       = 4;
   localparam int         RTCAC_TICK_64HZ       = 1;
   // source select codes, in the register's encoding order
   typedef enum logic [1:0] {
      RTCAC_SRC_4096HZ,
      RTCAC_SRC_64HZ,
      RTCAC_SRC_1HZ,
      RTCAC_SRC_60S
   } rtcac_src_e;
endpackage

// File: core/rtcac_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rtcac_tmr_if;
   import rtcac_pkg::*;
   logic [7:0] reload;    // stored reload value
   rtcac_src_e src_sel;   // countdown source
   logic       run;       // countdown enabled
   logic       reload_wr; // reload value just written
   logic       flag_clr;  // software clear of the flag
   logic [7:0] count;     // live countdown value
   logic       flag;      // sticky expiry flag
   logic       pulse;     // expiry pulse for pulse style
   modport ctl (output reload, src_sel, run, reload_wr, flag_clr, input count, flag, pulse);
   modport tmr (input reload, src_sel, run, reload_wr, flag_clr, output count, flag, pulse);
endinterface // rtcac_tmr_if
`default_nettype wire

// File: core/rtcac_countdown.sv
`timescale 1ns/1ps
`default_nettype none
module rtcac_countdown
   import rtcac_pkg::*;
(
   input  wire logic                       clk,      // core clock
   input  wire logic                       rst_b,    // async reset, low
   input  wire logic                       ce,       // clock enable
   input  wire logic [RTCAC_NUM_TICKS-1:0] src_tick, // timebase strobes
   rtcac_tmr_if.tmr                        tif       // control and status
);
   logic [7:0] count;      // countdown value
   logic       flag;       // expiry flag
   logic       pulse;      // expiry pulse
   logic [7:0] next_count; // next countdown value
   logic       next_flag;  // next flag
   logic       next_pulse; // next pulse
   logic       sel_tick;   // selected source strobe
   logic       end_tick;   // strobe that ends the pulse
   logic       expire;     // decrement from one this cycle

   // pulse ends on the next fast strobe; slow sources use the 64 Hz lane
   assign sel_tick = src_tick[tif.src_sel];
   assign end_tick = (tif.src_sel == RTCAC_SRC_4096HZ) ? src_tick[RTCAC_SRC_4096HZ] : src_tick[RTCAC_TICK_64HZ];

   // next countdown state
   always_comb begin
      next_count = count;
      next_flag  = flag;
      next_pulse = pulse;
      expire     = 1'b0;
      if (!tif.run) begin
         next_count = RTCAC_CD_ZERO;
      end else if (tif.reload == RTCAC_CD_ZERO) begin
         next_count = RTCAC_CD_ZERO;
      end else if (count == RTCAC_CD_ZERO || tif.reload_wr) begin
         // fresh start or new value takes effect at once
         next_count = tif.reload;
      end else if (sel_tick) begin
         if (count == RTCAC_CD_ONE) begin
            next_count = tif.reload;
            expire     = 1'b1;
         end else begin
            next_count = count - RTCAC_CD_ONE;
         end
      end
      // expiry wins over a clear in the same cycle
      if (expire) begin
         next_flag = 1'b1;
      end else if (tif.flag_clr) begin
         next_flag = 1'b0;
      end
      if (expire) begin
         next_pulse = 1'b1;
      end else if (end_tick) begin
         next_pulse = 1'b0;
      end
   end

   // state registers, frozen while ce is low
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= RTCAC_CD_ZERO;
         flag  <= 1'b0;
         pulse <= 1'b0;
      end else if (ce) begin
         count <= next_count;
         flag  <= next_flag;
         pulse <= next_pulse;
      end
   end

   assign tif.count = count;
   assign tif.flag  = flag;
   assign tif.pulse = pulse;

   // a stopped timer holds zero
   AST_CD_STOP: assert property (@(posedge clk) disable iff (!rst_b)
      ce && !tif.run |=> count == RTCAC_CD_ZERO)
      else $error("countdown not cleared while stopped");
   // decrement from one reloads and flags
   AST_CD_EXPIRE: assert property (@(posedge clk) disable iff (!rst_b)
      ce && tif.run && tif.reload != RTCAC_CD_ZERO && !tif.reload_wr && sel_tick && count == RTCAC_CD_ONE
      |=> flag && count == $past(tif.reload))
      else $error("countdown expiry did not reload and flag");
   // one step per selected strobe
   AST_CD_STEP: assert property (@(posedge clk) disable iff (!rst_b)
      ce && tif.run && tif.reload != RTCAC_CD_ZERO && !tif.reload_wr && sel_tick && count > RTCAC_CD_ONE
      |=> count == $past(count) - RTCAC_CD_ONE)
      else $error("countdown did not step by one");
   // zero reload halts
   AST_CD_HALT: assert property (@(posedge clk) disable iff (!rst_b)
      ce && tif.reload == RTCAC_CD_ZERO |=> count == RTCAC_CD_ZERO && !$rose(flag))
      else $error("countdown ran with zero reload");
endmodule // rtcac_countdown
`default_nettype wire

// File: test/rtcac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the byte register port and the flag clears
module rtcac_host_model
   import rtcac_pkg::*;
(
   output logic [7:0] reg_addr,  // register offset
   output logic [7:0] reg_wdata, // write data
   output logic       reg_wr,    // write strobe
   output logic       rd_go,     // read offset presented
   output logic       af_clr,    // alarm flag clear
   output logic       cf_clr,    // countdown flag clear
   input  wire logic  clk        // core clock
);
   // idle levels from time zero
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      rd_go     = 1'b0;
      af_clr    = 1'b0;
      cf_clr    = 1'b0;
   end
   // one byte, strobe held for exactly one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~d; // stale data must not look valid
   endtask
   // offset is taken at the next edge, data one edge later
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      rd_go    <= 1'b1;
      @(posedge clk);
      rd_go    <= 1'b0;
   endtask
   // software clear, a one-cycle pulse
   task automatic clr(input logic alarm);
      @(posedge clk);
      af_clr <= alarm;
      cf_clr <= !alarm;
      @(posedge clk);
      af_clr <= 1'b0;
      cf_clr <= 1'b0;
   endtask
   // stop before a new reload so the first period is clean
   task automatic set_timer(input logic [7:0] ctrl, input logic [7:0] t);
      wr(RTCAC_CD_CTRL_ADDR, ctrl & 8'hfb);
      wr(RTCAC_CD_VALUE_ADDR, t);
      wr(RTCAC_CD_CTRL_ADDR, ctrl);
   endtask
endmodule // rtcac_host_model
`default_nettype wire

// File: test/rtcac_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rtcac_top_tb_top;
   import rtcac_pkg::*;
   typedef struct { string what; logic [7:0] exp; } rtcac_exp_s;
   logic            clk, rst_b, ce;       // clock, reset, enable
   logic [7:0]      reg_addr, reg_wdata;  // register port
   logic            reg_wr, rd_go, rd_seen; // strobes
   logic [7:0]      reg_rdata;            // read data
   logic [4:0][7:0] cur;                  // weekday..second
   logic            cal_update, pin_go;   // update and probe
   logic [3:0]      src_tick;             // source strobes
   logic            alarm_irq_enable, af_clr, cf_clr; // control
   logic            alarm_flag, countdown_flag, int_o, int_oe; // status
   rtcac_exp_s      q[$];                 // expected results
   int              errors, tests_run;    // counters
   logic [7:0]      d;                    // write data
   // expected reset values and readable bits, offsets 0b..11
   logic [7:0] rv[7] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h18};
   logic [7:0] msk[7] = '{8'hff, 8'hff, 8'hbf, 8'hbf, 8'h87, 8'h00, 8'h1f};
   rtcac_top dut (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .cur_sec(cur[0]),
      .cur_min(cur[1]), .cur_hour(cur[2]), .cur_day(cur[3]), .cur_wday(cur[4]),
      .cal_update(cal_update), .src_tick(src_tick), .alarm_irq_enable(alarm_irq_enable),
      .alarm_flag_clear(af_clr), .countdown_flag_clear(cf_clr), .alarm_flag(alarm_flag),
      .countdown_flag(countdown_flag), .int_o(int_o), .int_oe(int_oe));
   rtcac_host_model host (.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .rd_go(rd_go), .af_clr(af_clr), .cf_clr(cf_clr), .clk(clk));
   // free-running 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // read data is valid one edge after the offset is taken
   always @(posedge clk) rd_seen <= rd_go;
   // compare mid-cycle, when outputs have settled
   always @(negedge clk) begin
      if (rd_seen === 1'b1) cmp("reg", reg_rdata);
      if (pin_go === 1'b1) cmp("pins", {4'h0, alarm_flag, countdown_flag, int_oe, int_o});
   end
   // oldest note against what was seen
   task automatic cmp(input string kind, input logic [7:0] got);
      rtcac_exp_s e;
      tests_run++;
      if (q.size() == 0) begin
         errors++;
         $display("BAD %s no expectation got %h", kind, got);
         return;
      end
      e = q.pop_front();
      if (got !== e.exp) begin
         errors++;
         $display("BAD %s %s exp %h got %h", kind, e.what, e.exp, got);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      q.push_back('{$sformatf("off %h", a), e});
      host.rd(a);
   endtask
   // pins packed as flag, countdown flag, enable, level
   task automatic pin_chk(input logic [7:0] e);
      q.push_back('{"pins", e});
      @(posedge clk);
      pin_go <= 1'b1;
      @(posedge clk);
      pin_go <= 1'b0;
   endtask
   // calendar advance with new counter values
   task automatic cal(input logic [4:0][7:0] v);
      @(posedge clk);
      cur        <= v;
      cal_update <= 1'b1;
      @(posedge clk);
      cal_update <= 1'b0;
   endtask
   task automatic tick(input int lane);
      @(posedge clk);
      src_tick <= 4'b0001 << lane;
      @(posedge clk);
      src_tick <= 4'h0;
   endtask
   task automatic final_report;
      $display("comparisons %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      final_report();
   end
   // main sequence
   initial begin
      rst_b = 1'b0;
      cur = '0;
      cal_update = 1'b0;
      src_tick = 4'h0;
      alarm_irq_enable = 1'b0;
      pin_go = 1'b0;
      ce = 1'b1;
      errors = 0;
      tests_run = 0;
      void'($urandom(32'h443b));
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      // reset values, masking of reserved bits, unmapped offset
      for (int i = 0; i < 7; i++) rd_chk(8'h0b + 8'(i), rv[i]);
      rd_chk(8'h20, 8'h00);
      for (int i = 0; i < 7; i++) begin
         for (int j = 0; j < 2; j++) begin
            d = j ? 8'($urandom()) : 8'hff;
            if (i == 6) d[2] = 1'b0;
            host.wr(8'h0b + 8'(i), d);
            rd_chk(8'h0b + 8'(i), d & msk[i]);
         end
         host.wr(8'h0b + 8'(i), rv[i]);
      end
      // minute field alone enabled, interrupt masked then shown
      host.wr(RTCAC_MIN_MATCH_ADDR, 8'h25);
      cal({8'h03, 8'h15, 8'h12, 8'h25, 8'h07});
      pin_chk(8'h08);
      alarm_irq_enable <= 1'b1;
      pin_chk(8'h0a);
      host.clr(1'b1);
      cal({8'h03, 8'h15, 8'h12, 8'h25, 8'h08});
      pin_chk(8'h00);
      cal({8'h03, 8'h15, 8'h12, 8'h26, 8'h09});
      cal({8'h03, 8'h15, 8'h12, 8'h25, 8'h0a});
      pin_chk(8'h0a);
      host.clr(1'b1);
      // weekday joins: both must match
      host.wr(RTCAC_WDAY_MATCH_ADDR, 8'h04);
      cal({8'h03, 8'h15, 8'h12, 8'h26, 8'h0b});
      cal({8'h03, 8'h15, 8'h12, 8'h25, 8'h0c});
      pin_chk(8'h00);
      cal({8'h04, 8'h15, 8'h12, 8'h25, 8'h0d});
      pin_chk(8'h0a);
      host.clr(1'b1);
      alarm_irq_enable <= 1'b0;
      // every field disabled: nothing can match
      host.wr(RTCAC_MIN_MATCH_ADDR, 8'h80);
      host.wr(RTCAC_WDAY_MATCH_ADDR, 8'h80);
      cal({8'h05, 8'h16, 8'h13, 8'h27, 8'h0e});
      pin_chk(8'h00);
      // clock enable low: a write must be dropped
      ce <= 1'b0;
      host.wr(RTCAC_MIN_MATCH_ADDR, 8'h11);
      ce <= 1'b1;
      rd_chk(RTCAC_MIN_MATCH_ADDR, 8'h80);
      // each source code; the next lane, wrapping from 3 to lane 0, must not count
      for (int s = 0; s < 4; s++) begin
         host.set_timer({3'b000, 2'(s), 1'b1, s[0], 1'b0}, 8'h02);
         rd_chk(RTCAC_CD_VALUE_ADDR, 8'h02);
         tick((s + 1) % 4);
         rd_chk(RTCAC_CD_VALUE_ADDR, 8'h02);
         tick(s);
         rd_chk(RTCAC_CD_VALUE_ADDR, 8'h01);
         tick(s);
         pin_chk(s[0] ? 8'h06 : 8'h04);
         rd_chk(RTCAC_CD_VALUE_ADDR, 8'h02);
         host.clr(1'b0);
      end
      // zero reload halts
      host.set_timer(8'h16, 8'h00);
      tick(2);
      tick(2);
      rd_chk(RTCAC_CD_VALUE_ADDR, 8'h00);
      pin_chk(8'h00);
      // pulse style ends at the next 64 Hz strobe, flag stays
      host.set_timer(8'h17, 8'h01);
      tick(2);
      pin_chk(8'h06);
      tick(1);
      pin_chk(8'h04);
      host.clr(1'b0);
      host.wr(RTCAC_CD_CTRL_ADDR, 8'h10);
      rd_chk(RTCAC_CD_VALUE_ADDR, 8'h00);
      pin_chk(8'h00);
      repeat (4) @(posedge clk);
      final_report();
   end
endmodule // rtcac_top_tb_top
`default_nettype wire
